// File: core/bsc_defines.svh
// Constants for the speed-command and spin-up block
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define BSC_ADDR_CONFIG 8'h00
`define BSC_ADDR_STATUS 8'h04
`define BSC_ADDR_FREQ   8'h08
`define BSC_CONFIG_RESET 32'h0000_0ff0
// Config field positions
`define BSC_MIN_LSB   0
`define BSC_HO_LSB    4
`define BSC_TARA_LSB  8
// ----------------------------------------
// Duty levels in 1/512 units
// ----------------------------------------
`define BSC_DUTY_STANDBY 9'h008
`define BSC_DUTY_MIN5    9'h01a
`define BSC_DUTY_MIN10   9'h033
`define BSC_DUTY_MIN13   9'h043
`define BSC_DUTY_SUP43   9'h0dc
`define BSC_DUTY_SUP50   9'h100
`define BSC_DUTY_SUP60   9'h133
`define BSC_DUTY_SUP75   9'h180
`define BSC_DUTY_SUP100  9'h1ff
// ----------------------------------------
// Timing
// ----------------------------------------
`define BSC_CLK_HZ        20000000
`define BSC_PWM_HZ        25000
`define BSC_PWM_CYCLES    (`BSC_CLK_HZ / `BSC_PWM_HZ)
`define BSC_MS_US         1000
`define BSC_US_CYCLES     (`BSC_CLK_HZ / 1000000)
`define BSC_TAU_MS        80
`define BSC_ALIGN_STEP_MS 40
`define BSC_HO_STEP_MHZ   12500
`define BSC_ACC_BASE_MHZ  160
`define BSC_ACC_STEP_MHZ  10
`endif

// File: core/bsc_pkg.sv
// Types for the speed-command and spin-up block
package bsc_pkg;
  // Start-up sequence states
  typedef enum logic [1:0]
  {
    BSC_STANDBY,
    BSC_ALIGN,
    BSC_OPEN_LOOP,
    BSC_CLOSED_LOOP
  } bsc_state_e;
endpackage

// File: core/bsc_duty_filter.sv
// First-order low-pass filter of the measured duty
`timescale 1ns/1ps
`default_nettype none
module bsc_duty_filter #(
  parameter int STEP_CYCLES = 100000,
  parameter int SHIFT       = 4
)(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Raw and filtered duty
  input  wire logic [8:0] duty_raw,
  output logic      [8:0] duty_filt
);
  initial if (STEP_CYCLES < 1 || STEP_CYCLES > 131072 || SHIFT < 1 || SHIFT > 8)
    $error("bad filter setting");
  logic [16:0] acc;     // Filter state with SHIFT fraction bits
  logic [16:0] step_cnt; // Update interval counter
  wire         step_now = (step_cnt == 17'(STEP_CYCLES - 1));
  wire  [17:0] target   = {1'b0, duty_raw, 8'h00} >> (8 - SHIFT);
  wire  [17:0] delta    = target - {1'b0, acc};
  // Tau equals STEP_CYCLES times 2^SHIFT clocks
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      acc      <= 17'h0;
      step_cnt <= 17'h0;
    end
    else
    begin
      step_cnt <= step_now ? 17'h0 : step_cnt + 17'h1;
      if (step_now)
        acc <= acc + 17'($signed(delta) >>> SHIFT);
    end
  end
  assign duty_filt = acc[SHIFT +: 9];
endmodule
`default_nettype wire

// File: core/bsc_phase_pwm.sv
// Three-phase fixed-frequency PWM generator
`timescale 1ns/1ps
`default_nettype none
module bsc_phase_pwm #(
  parameter int PERIOD = 800
)(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Phase levels in 1/512 units, U in bits 8:0
  input  wire logic [26:0] level,
  // Pin drive
  output logic      [2:0]  phase_out
);
  initial if (PERIOD < 2 || PERIOD > 1023) $error("bad pwm period");
  logic [9:0] cnt; // Carrier counter
  // Free-running carrier
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      cnt <= 10'h0;
    else
      cnt <= (cnt == 10'(PERIOD - 1)) ? 10'h0 : cnt + 10'h1;
  end
  // One comparator per phase
  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_ph
      wire [19:0] thr = (20'(level[9*p +: 9]) * 20'(PERIOD)) >> 9;
      always_ff @(posedge sys_clk or posedge reset)
      begin
        if (reset)
          phase_out[p] <= 1'b0;
        else
          phase_out[p] <= (20'(cnt) < thr);
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: core/bsc_spinup.sv
// Speed-command shaping and start-up sequencer top
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defines.svh"
module bsc_spinup #(
  parameter int SAMPLE_CYCLES = 4,
  parameter int FILT_STEP     = 100000,
  parameter int MS_CYCLES     = 20000
)(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // AXI4-Lite write address
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Command and strap pins
  input  wire logic                 pwm_in,
  input  wire logic                 direction_sel,
  input  wire logic [2:0]           supply_band,
  // Motor phase pins
  output logic [2:0]                phase_out,
  output logic [2:0]                phase_drive_en,
  // Status
  output bsc_pkg::bsc_state_e       state
);
  import bsc_pkg::*;

  initial if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 65536 || MS_CYCLES < 2 ||
              MS_CYCLES > 65536 || FILT_STEP < 1) $error("bad timing");

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  logic [31:0] config_reg;        // Start-up settings
  wire  [1:0]  min_duty_sel     = config_reg[`BSC_MIN_LSB +: 2];
  wire  [3:0]  handoff_raw      = config_reg[`BSC_HO_LSB +: 4];
  wire  [3:0]  align_raw        = config_reg[`BSC_TARA_LSB +: 4];
  // Reserved code 0 behaves as code 1
  wire  [3:0]  handoff_freq_sel = (handoff_raw == 4'h0) ? 4'h1 : handoff_raw;
  wire  [3:0]  align_accel_sel  = (align_raw == 4'h0) ? 4'h1 : align_raw;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic        aw_held;           // Write address taken
  logic [7:0]  aw_addr;           // Held write address
  logic        w_held;            // Write data taken
  logic [31:0] w_data;            // Held write data
  logic [3:0]  w_strb;            // Held strobes
  wire         wr_go    = aw_held && w_held && !s_axi_bvalid;
  wire         wr_hit   = (aw_addr == `BSC_ADDR_CONFIG);
  wire         wr_ro    = (aw_addr == `BSC_ADDR_STATUS) || (aw_addr == `BSC_ADDR_FREQ);
  wire         rd_go    = s_axi_arvalid && s_axi_arready;
  wire         rd_hit   = (s_axi_araddr == `BSC_ADDR_CONFIG) || (s_axi_araddr == `BSC_ADDR_STATUS)
                          || (s_axi_araddr == `BSC_ADDR_FREQ);
  logic [31:0] status_word;       // State and command readback
  logic [31:0] freq_mhz;          // Commutation rate in mHz
  wire  [31:0] rd_word  = (s_axi_araddr == `BSC_ADDR_CONFIG) ? config_reg :
                          (s_axi_araddr == `BSC_ADDR_STATUS) ? status_word :
                          (s_axi_araddr == `BSC_ADDR_FREQ)   ? freq_mhz : 32'h0;
  logic [31:0] strb_mask;         // Byte-lane mask from strobes

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // Expand byte strobes into a bit mask
  always_comb
  begin
    strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  end

  // Address and data capture in either order, then respond
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      config_reg   <= `BSC_CONFIG_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_hit || wr_ro) ? 2'b00 : 2'b10;
        if (wr_hit)
          config_reg <= ((config_reg & ~strb_mask) | (w_data & strb_mask)) & 32'h0000_0ff3;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // Duty measurement and filtering
  // ----------------------------------------
  logic [15:0] samp_cnt;          // Sample spacing counter
  logic [8:0]  samp_idx;          // Sample number in window
  logic [9:0]  ones;              // High samples in window
  logic [8:0]  duty_raw;          // Last window result
  logic [8:0]  duty_filt;         // Filtered command
  wire         samp_now = (samp_cnt == 16'(SAMPLE_CYCLES - 1));
  wire  [9:0]  ones_nx  = ones + {9'h0, pwm_in};

  // Count high samples over 512 samples, clamp to 511
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      samp_cnt <= 16'h0;
      samp_idx <= 9'h0;
      ones     <= 10'h0;
      duty_raw <= 9'h0;
    end
    else
    begin
      samp_cnt <= samp_now ? 16'h0 : samp_cnt + 16'h1;
      if (samp_now)
      begin
        samp_idx <= samp_idx + 9'h1;
        if (samp_idx == 9'h1ff)
        begin
          duty_raw <= ones_nx[9] ? 9'h1ff : ones_nx[8:0];
          ones     <= 10'h0;
        end
        else
          ones <= ones_nx;
      end
    end
  end

  bsc_duty_filter #(
    .STEP_CYCLES (FILT_STEP),
    .SHIFT       (4)
  ) u_filter (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .duty_raw  (duty_raw),
    .duty_filt (duty_filt)
  );

  // ----------------------------------------
  // Command shaping
  // ----------------------------------------
  wire  [8:0] min_duty   = (min_duty_sel == 2'd1) ? `BSC_DUTY_MIN5 :
                           (min_duty_sel == 2'd2) ? `BSC_DUTY_MIN10 :
                           (min_duty_sel == 2'd3) ? `BSC_DUTY_MIN13 : 9'h000;
  wire        go_standby = (duty_filt < `BSC_DUTY_STANDBY);
  wire  [8:0] run_duty   = (duty_filt > min_duty) ? duty_filt : min_duty;
  wire  [8:0] supply_duty = (supply_band == 3'd4) ? `BSC_DUTY_SUP43 :
                            (supply_band == 3'd3) ? `BSC_DUTY_SUP50 :
                            (supply_band == 3'd2) ? `BSC_DUTY_SUP60 :
                            (supply_band == 3'd1) ? `BSC_DUTY_SUP75 : `BSC_DUTY_SUP100;

  // ----------------------------------------
  // Start-up timing
  // ----------------------------------------
  logic [15:0] ms_cnt;            // Millisecond prescaler
  logic [4:0]  us_cnt;            // Microsecond prescaler
  logic [15:0] align_ms;          // Milliseconds spent aligning
  wire         ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));
  wire         us_tick = (us_cnt == 5'(`BSC_US_CYCLES - 1));
  wire  [15:0] align_len = 16'(align_accel_sel) * 16'(`BSC_ALIGN_STEP_MS);
  wire  [31:0] accel_mhz = 32'(`BSC_ACC_BASE_MHZ - `BSC_ACC_STEP_MHZ * align_accel_sel);
  wire  [31:0] handoff_freq = 32'(handoff_freq_sel) * 32'(`BSC_HO_STEP_MHZ);
  // Per-microsecond angle step, about f_mHz * 2^32 / 1e9
  wire  [45:0] step_wide = 46'(freq_mhz) * 46'd4398;
  wire  [31:0] angle_step = step_wide[41:10];
  logic [31:0] angle;             // Electrical angle of phase U
  bsc_state_e  next_state;        // Sequencer next state

  // Millisecond prescaler waits in standby, so alignment spans whole milliseconds
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ms_cnt <= 16'h0;
      us_cnt <= 5'h0;
    end
    else
    begin
      ms_cnt <= (ms_tick || state == BSC_STANDBY) ? 16'h0 : ms_cnt + 16'h1;
      us_cnt <= us_tick ? 5'h0 : us_cnt + 5'h1;
    end
  end

  // Sequencer transitions
  always_comb
  begin
    next_state = state;
    unique case (state)
      BSC_STANDBY:
        if (!go_standby)
          next_state = BSC_ALIGN;
      BSC_ALIGN:
        if (go_standby)
          next_state = BSC_STANDBY;
        else if (ms_tick && (align_ms + 16'h1 >= align_len))
          next_state = BSC_OPEN_LOOP;
      BSC_OPEN_LOOP:
        if (go_standby)
          next_state = BSC_STANDBY;
        else if (freq_mhz >= handoff_freq)
          next_state = BSC_CLOSED_LOOP;
      BSC_CLOSED_LOOP:
        if (go_standby)
          next_state = BSC_STANDBY;
    endcase
  end

  // State, alignment timer, rate ramp and angle
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state    <= BSC_STANDBY;
      align_ms <= 16'h0;
      freq_mhz <= 32'h0;
      angle    <= 32'h0;
    end
    else
    begin
      state    <= next_state;
      align_ms <= (state == BSC_ALIGN && ms_tick) ? align_ms + 16'h1 :
                  (state == BSC_ALIGN) ? align_ms : 16'h0;
      if (state == BSC_OPEN_LOOP && ms_tick && freq_mhz < handoff_freq)
        freq_mhz <= freq_mhz + accel_mhz;
      else if (state == BSC_STANDBY || state == BSC_ALIGN)
        freq_mhz <= 32'h0;
      if (state == BSC_STANDBY || state == BSC_ALIGN)
        angle <= 32'h0;
      else if (us_tick)
        angle <= angle + angle_step;
    end
  end

  // ----------------------------------------
  // Waveform synthesis
  // ----------------------------------------
  // Sine table, 16 points, 1..255 around 128
  function automatic logic [7:0] sine16(input logic [3:0] idx);
    logic [7:0] v;
    v = 8'h80;
    unique case (idx)
      4'h0: v = 8'h80;
      4'h1: v = 8'hb1;
      4'h2: v = 8'hda;
      4'h3: v = 8'hf6;
      4'h4: v = 8'hff;
      4'h5: v = 8'hf6;
      4'h6: v = 8'hda;
      4'h7: v = 8'hb1;
      4'h8: v = 8'h80;
      4'h9: v = 8'h4f;
      4'ha: v = 8'h26;
      4'hb: v = 8'h0a;
      4'hc: v = 8'h01;
      4'hd: v = 8'h0a;
      4'he: v = 8'h26;
      4'hf: v = 8'h4f;
    endcase
    return v;
  endfunction

  // Second and third phase lag by a third or two thirds
  wire [31:0] ang_v  = direction_sel ? angle - 32'h5555_5555 : angle - 32'haaaa_aaaa;
  wire [31:0] ang_w  = direction_sel ? angle - 32'haaaa_aaaa : angle - 32'h5555_5555;
  wire [7:0]  s_u    = sine16(angle[31:28]);
  wire [7:0]  s_v    = sine16(ang_v[31:28]);
  wire [7:0]  s_w    = sine16(ang_w[31:28]);
  // Clamp lowest phase to zero so one output is always grounded
  wire [7:0]  s_min  = (s_u < s_v) ? ((s_u < s_w) ? s_u : s_w) : ((s_v < s_w) ? s_v : s_w);
  wire [8:0]  amp    = (state == BSC_CLOSED_LOOP) ? run_duty : supply_duty;
  wire [16:0] lv_u   = 17'(s_u - s_min) * 17'(amp);
  wire [16:0] lv_v   = 17'(s_v - s_min) * 17'(amp);
  wire [16:0] lv_w   = 17'(s_w - s_min) * 17'(amp);
  logic [26:0] level;             // Phase levels W,V,U

  // Align holds U low and drives V and W at the supply duty
  always_comb
  begin
    unique case (state)
      BSC_STANDBY:
        level = 27'h0;
      BSC_ALIGN:
        level = {supply_duty, supply_duty, 9'h000};
      default:
        level = {lv_w[16:8], lv_v[16:8], lv_u[16:8]};
    endcase
  end

  bsc_phase_pwm #(
    .PERIOD (`BSC_PWM_CYCLES)
  ) u_pwm (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .level     (level),
    .phase_out (phase_out)
  );

  // Outputs released in standby
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      phase_drive_en <= 3'b000;
    else
      phase_drive_en <= (next_state == BSC_STANDBY) ? 3'b000 : 3'b111;
  end

  // Status readback: state in 1:0, filtered duty in 24:16
  always_comb
  begin
    status_word = {7'h0, duty_filt, 14'h0, state};
  end
endmodule
`default_nettype wire

// File: tb/bsc_spinup_monitor.sv
// Concurrent checks on the spin-up block ports
`timescale 1ns/1ps
`default_nettype none
module bsc_spinup_monitor #(
  parameter int MS_CYCLES = 20000
)(
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                reset,
  // Bus answers
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic [31:0]         s_axi_rdata,
  // Motor side
  input wire logic [2:0]          phase_out,
  input wire logic [2:0]          phase_drive_en,
  input wire bsc_pkg::bsc_state_e state
);
  import bsc_pkg::*;
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  int unsigned align_run;  // Cycles spent in the current alignment
  // Counts consecutive alignment cycles
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      align_run <= 0;
    else if (state == BSC_ALIGN)
      align_run <= align_run + 1;
    else
      align_run <= 0;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  read_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  standby_off_a:
    assert property ((state == BSC_STANDBY) [*2] |-> phase_drive_en == 3'b000)
    else $error("drive enabled in standby");
  drive_on_a:
    assert property ((state != BSC_STANDBY) [*2] |-> phase_drive_en == 3'b111)
    else $error("drive off while running");
  standby_quiet_a:
    assert property ((state == BSC_STANDBY) [*4] |-> phase_out == 3'b000)
    else $error("phases switch in standby");
  align_u_low_a:
    assert property ((state == BSC_ALIGN) [*4] |-> phase_out[0] == 1'b0)
    else $error("phase U not grounded in align");
  state_step_a:
    assert property ($changed(state) && state != BSC_STANDBY |-> 2'(state) == 2'($past(state)) + 2'd1)
    else $error("start-up state skipped");
  align_len_a:
    assert property (align_run <= 600 * MS_CYCLES + 2)
    else $error("alignment too long");
endmodule
bind bsc_spinup bsc_spinup_monitor #(.MS_CYCLES(MS_CYCLES)) bsc_spinup_monitor_i (
  .sys_clk(sys_clk), .reset(reset), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata), .phase_out(phase_out),
  .phase_drive_en(phase_drive_en), .state(state));
`default_nettype wire

// File: tb/bsc_pwm_source.sv
// Host duty command source driving the pulse input
`timescale 1ns/1ps
`default_nettype none
module bsc_pwm_source #(
  parameter int SAMPLE_CYCLES = 1
)(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Requested duty in 1/512 units
  input  wire logic [8:0] duty,
  // Pulse command pin
  output logic            pwm_in
);
  logic [8:0] pos;  // Position in the 512-sample period
  int         sub;  // Clocks within one sample
  // High while the position is below the requested duty
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pos    <= 9'h000;
      sub    <= 0;
      pwm_in <= 1'b0;
    end
    else if (sub == SAMPLE_CYCLES - 1)
    begin
      sub    <= 0;
      pos    <= pos + 9'h001;
      pwm_in <= (pos < duty);
    end
    else
      sub <= sub + 1;
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the spin-up block
`timescale 1ns/1ps
`default_nettype none
`include "bsc_defines.svh"
module tb_top;
  import bsc_pkg::*;
  localparam int MS = 20;  // Clocks per millisecond, shortened
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        sys_clk, reset, pwm_in, direction_sel;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [2:0]  supply_band, phase_out, phase_drive_en;
  logic [8:0]  duty;
  bsc_state_e  state;
  int          n_mismatch, cmp_count;
  int          n0, n1, n2;  // V-phase high counts at three commands
  int          st_cnt [4];  // Cycles spent in each state
  logic [8:0]  lv [5] = '{`BSC_DUTY_SUP100, `BSC_DUTY_SUP75, `BSC_DUTY_SUP60,
                          `BSC_DUTY_SUP50, `BSC_DUTY_SUP43};
  // ----------------------------------------
  // Instances, clock, watchdog
  // ----------------------------------------
  bsc_spinup #(.SAMPLE_CYCLES(1), .FILT_STEP(4), .MS_CYCLES(MS)) bsc_spinup_i (.*);
  bsc_pwm_source #(.SAMPLE_CYCLES(1)) bsc_pwm_source_i (.sys_clk(sys_clk), .reset(reset),
    .duty(duty), .pwm_in(pwm_in));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Counts time in each state
  always @(posedge sys_clk)
    if (!reset) st_cnt[state] <= st_cnt[state] + 1;
  // Cuts a hang short
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus write; releases each channel at the edge it is taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid  <= s_axi_wvalid && !s_axi_wready;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // One bus read compared against expected data and response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge sys_clk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check("rdata", s_axi_rdata, ed);
    check("rresp", 32'(s_axi_rresp), 32'(er));
  endtask
  task automatic wait_state(input bsc_state_e s);
    for (int t = 0; t < 60000 && state !== s; t++) @(posedge sys_clk);
    check("state", 32'(state), 32'(s));
  endtask
  // Starts the motor and times alignment and ramp
  task automatic spin(input logic [31:0] cfg, input int al_ms, input int step, input int ho,
                      input bit bands);
    int n, e;
    axi_wr(`BSC_ADDR_CONFIG, cfg, r);
    st_cnt = '{default: 0};
    duty <= 9'd200;
    wait_state(BSC_ALIGN);
    for (int b = 0; b < 5 && bands; b++)
    begin
      supply_band <= 3'(b);
      repeat (800) @(posedge sys_clk);
      n = 0;
      repeat (800) @(posedge sys_clk) n += int'(phase_out[1]);
      e = int'(lv[b]) * 800 / 512;
      check("v_duty", 32'(n > e - 4 && n < e + 4), 32'd1);
    end
    wait_state(BSC_OPEN_LOOP);
    n = 0;
    e = 0;
    repeat (2) @(posedge sys_clk);
    repeat (800) @(posedge sys_clk)
    begin
      n += int'(phase_out[1]);
      e += int'(phase_out[2]);
    end
    check("lag", 32'(direction_sel ? n == 0 && e > 0 : e == 0 && n > 0), 32'd1);
    wait_state(BSC_CLOSED_LOOP);
    e = al_ms * MS;
    check("align_len", 32'(st_cnt[1] > e - 5 && st_cnt[1] < e + 5), 32'd1);
    e = (ho + step - 1) / step * MS;
    check("ramp_len", 32'(st_cnt[2] > e - 2 * MS && st_cnt[2] < e + 2 * MS), 32'd1);
    rd_chk(`BSC_ADDR_FREQ, 32'((ho + step - 1) / step * step), 2'b00);
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h21;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, duty, supply_band} = '0;
    s_axi_wstrb   = 4'hf;
    direction_sel = 1'b1;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    rd_chk(`BSC_ADDR_CONFIG, `BSC_CONFIG_RESET, 2'b00);
    rd_chk(8'h0c, 32'h0, 2'b10);
    axi_wr(8'h0c, 32'hffff_ffff, r);
    check("wr_unmapped", 32'(r), 32'h2);
    axi_wr(`BSC_ADDR_STATUS, 32'hffff_ffff, r);
    axi_wr(`BSC_ADDR_CONFIG, 32'hffff_ffff, r);
    rd_chk(`BSC_ADDR_CONFIG, 32'h0000_0ff3, 2'b00);
    check("state", 32'(state), 32'(BSC_STANDBY));
    spin(32'h0000_0f13, 600, 10, 12500, 1'b1);
    duty <= 9'd0;
    wait_state(BSC_STANDBY);
    check("drive_en", 32'(phase_drive_en), 32'h0);
    direction_sel <= 1'b0;
    spin(32'h0000_0002, 40, 150, 12500, 1'b0);
    duty <= 9'd0;
    wait_state(BSC_STANDBY);
    spin(32'h0000_0121, 40, 150, 25000, 1'b0);
    repeat (800) @(posedge sys_clk) n0 += int'(phase_out[1]);
    duty <= 9'd20;
    repeat (2000) @(posedge sys_clk);
    repeat (800) @(posedge sys_clk) n1 += int'(phase_out[1]);
    duty <= 9'd12;
    repeat (2000) @(posedge sys_clk);
    repeat (800) @(posedge sys_clk) n2 += int'(phase_out[1]);
    check("min_clamp", 32'(n1 == n2 && n1 > 0), 32'd1);
    check("amp_follow", 32'(n0 > n1), 32'd1);
    check("state", 32'(state), 32'(BSC_CLOSED_LOOP));
    tally_and_finish;
  end
endmodule
`default_nettype wire
